// ===== design/gpsl_pkg.sv
// Package for the pin configuration and sense latch block
package gpsl_pkg;
    // ========================================
    // Register offsets
    localparam logic [11:0] OFF_HIT_FLAGS = 12'h020;
    localparam logic [11:0] OFF_STYLE_NS = 12'h024;
    localparam logic [11:0] OFF_STYLE_S = 12'h028;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h030;
    localparam logic [11:0] OFF_PIN_LEVEL = 12'h034;
    localparam logic [11:0] OFF_PIN_SECURE = 12'h038;
    localparam logic [11:0] OFF_PIN_SETUP = 12'h200;
    localparam logic [11:0] OFF_PIN_SETUP_END = 12'h27c;
    localparam int NUM_PINS = 32;
    // ========================================
    // Field positions within pin_setup
    localparam int F_DIR = 0;
    localparam int F_INBUF = 1;
    localparam int F_PULL_LO = 2;
    localparam int F_DRIVE_LO = 8;
    localparam int F_SENSE_LO = 16;
    localparam int F_OWNER_LO = 28;
    localparam logic [31:0] SETUP_MASK = 32'h70030f0f;
    localparam logic [31:0] OWNER_MASK = 32'h70000000;
    localparam logic [31:0] SETUP_RESET = 32'h00000002;
    localparam logic [31:0] FLAGS_RESET = 32'h00000000;
    localparam logic [31:0] STYLE_RESET = 32'h00000000;
    // ========================================
    // Encodings
    localparam logic [1:0] SENSE_OFF = 2'h0;
    localparam logic [1:0] SENSE_HIGH = 2'h2;
    localparam logic [1:0] SENSE_LOW = 2'h3;
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h3;
    localparam logic [3:0] STD_LOW_STD_HIGH = 4'h0;
    localparam logic [3:0] STRONG_LOW_STD_HIGH = 4'h1;
    localparam logic [3:0] STD_LOW_STRONG_HIGH = 4'h2;
    localparam logic [3:0] STRONG_LOW_STRONG_HIGH = 4'h3;
    localparam logic [3:0] OPEN_LOW_STD_HIGH = 4'h4;
    localparam logic [3:0] OPEN_LOW_STRONG_HIGH = 4'h5;
    localparam logic [3:0] STD_LOW_OPEN_HIGH = 4'h6;
    localparam logic [3:0] STRONG_LOW_OPEN_HIGH = 4'h7;
    localparam logic [3:0] EXTRA_STRONG_BOTH = 4'hb;
    localparam logic [2:0] OWNER_APPLICATION_CPU = 3'h0;
    localparam logic [2:0] OWNER_RADIO_CPU = 3'h1;
    localparam logic [2:0] OWNER_PERIPHERAL = 3'h3;
    localparam logic [2:0] OWNER_TRACE_DEBUG = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Drive strength per level: 0 undriven, 1 standard, 2 high, 3 extra
    localparam logic [1:0] STR_OPEN = 2'h0;
    localparam logic [1:0] STR_STD = 2'h1;
    localparam logic [1:0] STR_HIGH = 2'h2;
    localparam logic [1:0] STR_EXTRA = 2'h3;
    // ========================================
    // Carrier types
    typedef struct packed {
        logic [1:0] low_str;
        logic [1:0] high_str;
    } gpsl_drive_t;
    typedef struct packed {
        logic dir_out;
        logic inbuf_on;
        logic pull_up;
        logic pull_down;
        gpsl_drive_t drive;
        logic [2:0] owner;
    } gpsl_pad_t;
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_DO = 3'b010,
        WR_RESP = 3'b100
    } gpsl_wr_state_t;
endpackage

// ===== design/gpsl_top.sv
// Pin configuration, level sense latching and AXI4-Lite register slave
// ========================================
// Overview of operation
// - One sticky flag bit per pin, set when its sense condition is met.
// - Writing one to a flag clears it; writing zero leaves it.
// - Flags reset clear; zero means not met, one means met.
// - Non-secure detect-mode selector chooses default or sticky detect.
// - Separate secure detect-mode selector offers the same choice.
// - Thirty-two pin setup words at 0x200 with four-byte stride.
// - Direction bit: zero input, one output.
// - Input buffer zero connects; pull zero none, one down, three up.
// - Drive codes 0 to 3 and 11 select low and high strengths.
// - Codes 4,5 leave low undriven; 6,7 leave high undriven.
// - Sense zero off, two high level, three low level; sets flag.
// - Owner field: 0 application, 1 radio, 3 peripheral, 7 trace.
// - Owner field readable and writable only by secure accesses.
module gpsl_top (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] pin_level_i,
    input wire logic [31:0] pin_secure_i,
    output logic [31:0] pin_dir_out_o,
    output logic [31:0] pin_inbuf_on_o,
    output logic [31:0] pin_pull_up_o,
    output logic [31:0] pin_pull_down_o,
    output logic [127:0] pin_drive_o,
    output logic [95:0] pin_owner_o,
    output logic detect_ns_o,
    output logic detect_s_o,
    output logic irq_o
);
    // ========================================
    // Storage
    logic [31:0] setup_reg [gpsl_pkg::NUM_PINS];
    logic [31:0] hit_flags_reg;
    logic [31:0] style_ns_reg;
    logic [31:0] style_s_reg;
    logic [31:0] irq_mask_reg;
    gpsl_pkg::gpsl_wr_state_t wr_state_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [11:0] aw_addr_reg;
    logic aw_secure_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [31:0] hit_now;
    logic [31:0] hit_flags_next;
    logic [31:0] clear_bits;
    logic [31:0] wmask;
    logic wr_fire;

    // ========================================
    // Address decode and word helpers
    // AXI prot[1] low marks a secure access
    function automatic logic is_setup(input logic [11:0] a);
        is_setup = a >= gpsl_pkg::OFF_PIN_SETUP
            && a <= gpsl_pkg::OFF_PIN_SETUP_END && a[1:0] == 2'h0;
    endfunction

    function automatic logic known(input logic [11:0] a);
        known = is_setup(a) || a == gpsl_pkg::OFF_HIT_FLAGS
            || a == gpsl_pkg::OFF_STYLE_NS || a == gpsl_pkg::OFF_STYLE_S
            || a == gpsl_pkg::OFF_IRQ_MASK || a == gpsl_pkg::OFF_PIN_LEVEL
            || a == gpsl_pkg::OFF_PIN_SECURE;
    endfunction

    function automatic logic [4:0] pin_idx(input logic [11:0] a);
        pin_idx = a[6:2];
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // Byte strobes and field masks reach the setup words and the interrupt mask through this merge
    function automatic logic [31:0] merge_word(input logic [31:0] old,
        input logic [31:0] data, input logic [31:0] m);
        merge_word = (old & ~m) | (data & m);
    endfunction

    // Unmapped addresses answer with an error instead of passing silently
    function automatic logic [1:0] resp_of(input logic [11:0] a);
        resp_of = known(a) ? gpsl_pkg::RESP_OKAY : gpsl_pkg::RESP_SLVERR;
    endfunction

    function automatic gpsl_pkg::gpsl_drive_t drive_map(input logic [3:0] c);
        gpsl_pkg::gpsl_drive_t d;
        d = '{gpsl_pkg::STR_STD, gpsl_pkg::STR_STD};
        unique case (c)
            gpsl_pkg::STD_LOW_STD_HIGH:
                d = '{gpsl_pkg::STR_STD, gpsl_pkg::STR_STD};
            gpsl_pkg::STRONG_LOW_STD_HIGH:
                d = '{gpsl_pkg::STR_HIGH, gpsl_pkg::STR_STD};
            gpsl_pkg::STD_LOW_STRONG_HIGH:
                d = '{gpsl_pkg::STR_STD, gpsl_pkg::STR_HIGH};
            gpsl_pkg::STRONG_LOW_STRONG_HIGH:
                d = '{gpsl_pkg::STR_HIGH, gpsl_pkg::STR_HIGH};
            gpsl_pkg::OPEN_LOW_STD_HIGH:
                d = '{gpsl_pkg::STR_OPEN, gpsl_pkg::STR_STD};
            gpsl_pkg::OPEN_LOW_STRONG_HIGH:
                d = '{gpsl_pkg::STR_OPEN, gpsl_pkg::STR_HIGH};
            gpsl_pkg::STD_LOW_OPEN_HIGH:
                d = '{gpsl_pkg::STR_STD, gpsl_pkg::STR_OPEN};
            gpsl_pkg::STRONG_LOW_OPEN_HIGH:
                d = '{gpsl_pkg::STR_HIGH, gpsl_pkg::STR_OPEN};
            gpsl_pkg::EXTRA_STRONG_BOTH:
                d = '{gpsl_pkg::STR_EXTRA, gpsl_pkg::STR_EXTRA};
            // Unlisted codes fall back to standard on both levels
            default: d = '{gpsl_pkg::STR_STD, gpsl_pkg::STR_STD};
        endcase
        drive_map = d;
    endfunction

    // Decode one setup word into the pad controls it asks for
    function automatic gpsl_pkg::gpsl_pad_t pad_of(input logic [31:0] w);
        gpsl_pkg::gpsl_pad_t p;
        logic [1:0] pl;
        pl = w[gpsl_pkg::F_PULL_LO +: 2];
        p.dir_out = w[gpsl_pkg::F_DIR];
        p.inbuf_on = !w[gpsl_pkg::F_INBUF];
        // Pull code 2 is unlisted and leaves both pulls off
        p.pull_up = pl == gpsl_pkg::PULL_UP;
        p.pull_down = pl == gpsl_pkg::PULL_DOWN;
        p.drive = drive_map(w[gpsl_pkg::F_DRIVE_LO +: 4]);
        p.owner = w[gpsl_pkg::F_OWNER_LO +: 3];
        pad_of = p;
    endfunction

    // ========================================
    // Sense evaluation
    always_comb begin
        for (int i = 0; i < gpsl_pkg::NUM_PINS; i++) begin
            logic [1:0] sn;
            sn = setup_reg[i][gpsl_pkg::F_SENSE_LO +: 2];
            // Direction is ignored, so an output pin latches its own level
            // A disconnected input buffer cannot see the pin
            hit_now[i] = !setup_reg[i][gpsl_pkg::F_INBUF]
                && ((sn == gpsl_pkg::SENSE_HIGH && pin_level_i[i])
                || (sn == gpsl_pkg::SENSE_LOW && !pin_level_i[i]));
        end
    end

    // ========================================
    // AXI4-Lite write path
    assign wr_fire = wr_state_reg == gpsl_pkg::WR_DO;
    assign wmask = strb_mask(w_strb_reg);
    assign clear_bits = (wr_fire && aw_addr_reg == gpsl_pkg::OFF_HIT_FLAGS)
        ? (w_data_reg & wmask) : 32'h00000000;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            wr_state_reg <= gpsl_pkg::WR_IDLE;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            aw_secure_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpsl_pkg::RESP_OKAY;
        end else begin
            unique case (wr_state_reg)
                gpsl_pkg::WR_IDLE: begin
                    // Ready drops on a handshake, so no valid is taken twice
                    s_axi_awready <= !aw_have_reg
                        && !(s_axi_awvalid && s_axi_awready);
                    s_axi_wready <= !w_have_reg
                        && !(s_axi_wvalid && s_axi_wready);
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_have_reg <= 1'b1;
                        aw_addr_reg <= s_axi_awaddr;
                        aw_secure_reg <= !s_axi_awprot[1];
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_have_reg <= 1'b1;
                        w_data_reg <= s_axi_wdata;
                        w_strb_reg <= s_axi_wstrb;
                    end
                    if ((aw_have_reg || (s_axi_awvalid && s_axi_awready))
                        && (w_have_reg || (s_axi_wvalid && s_axi_wready))) begin
                        wr_state_reg <= gpsl_pkg::WR_DO;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                    end
                end
                gpsl_pkg::WR_DO: begin
                    aw_have_reg <= 1'b0;
                    w_have_reg <= 1'b0;
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp <= resp_of(aw_addr_reg);
                    wr_state_reg <= gpsl_pkg::WR_RESP;
                end
                gpsl_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wr_state_reg <= gpsl_pkg::WR_IDLE;
                    end
                end
            endcase
        end
    end

    // ========================================
    // Pin setup words
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < gpsl_pkg::NUM_PINS; i++) begin
                setup_reg[i] <= gpsl_pkg::SETUP_RESET;
            end
        end else if (wr_fire && is_setup(aw_addr_reg)) begin
            logic [31:0] m;
            // Unused bits are not stored, so they always read back as zero
            m = wmask & gpsl_pkg::SETUP_MASK;
            if (!aw_secure_reg) begin
                m = m & ~gpsl_pkg::OWNER_MASK;
            end
            setup_reg[pin_idx(aw_addr_reg)] <=
                merge_word(setup_reg[pin_idx(aw_addr_reg)], w_data_reg, m);
        end
    end

    // ========================================
    // Sticky flag next state
    // A new hit in the clearing cycle wins over the clear
    assign hit_flags_next = (hit_flags_reg & ~clear_bits)
        | hit_now;

    // ========================================
    // Sticky flags, detect selectors and interrupt mask
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            hit_flags_reg <= gpsl_pkg::FLAGS_RESET;
        end else begin
            hit_flags_reg <= hit_flags_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            style_ns_reg <= gpsl_pkg::STYLE_RESET;
            style_s_reg <= gpsl_pkg::STYLE_RESET;
            irq_mask_reg <= 32'h00000000;
        end else if (wr_fire) begin
            if (aw_addr_reg == gpsl_pkg::OFF_STYLE_NS) begin
                style_ns_reg[0] <= w_data_reg[0] && w_strb_reg[0]
                    ? 1'b1 : (w_strb_reg[0] ? 1'b0 : style_ns_reg[0]);
            end
            if (aw_addr_reg == gpsl_pkg::OFF_STYLE_S && aw_secure_reg) begin
                style_s_reg[0] <= w_data_reg[0] && w_strb_reg[0]
                    ? 1'b1 : (w_strb_reg[0] ? 1'b0 : style_s_reg[0]);
            end
            if (aw_addr_reg == gpsl_pkg::OFF_IRQ_MASK) begin
                irq_mask_reg <= merge_word(irq_mask_reg, w_data_reg, wmask);
            end
        end
    end

    // ========================================
    // Detect and interrupt outputs
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            detect_ns_o <= 1'b0;
            detect_s_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            // Default mode follows the live condition, sticky mode the flags
            detect_ns_o <= style_ns_reg[0]
                ? |(hit_flags_reg & ~pin_secure_i)
                : |(hit_now & ~pin_secure_i);
            detect_s_o <= style_s_reg[0]
                ? |(hit_flags_reg & pin_secure_i)
                : |(hit_now & pin_secure_i);
            irq_o <= |(hit_flags_reg & irq_mask_reg);
        end
    end

    // ========================================
    // Pad controls
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pin_dir_out_o <= 32'h00000000;
            pin_inbuf_on_o <= 32'h00000000;
            pin_pull_up_o <= 32'h00000000;
            pin_pull_down_o <= 32'h00000000;
            pin_drive_o <= '0;
            pin_owner_o <= '0;
        end else begin
            // Registered so the pads never see decode glitches
            for (int i = 0; i < gpsl_pkg::NUM_PINS; i++) begin
                gpsl_pkg::gpsl_pad_t p;
                p = pad_of(setup_reg[i]);
                pin_dir_out_o[i] <= p.dir_out;
                pin_inbuf_on_o[i] <= p.inbuf_on;
                pin_pull_up_o[i] <= p.pull_up;
                pin_pull_down_o[i] <= p.pull_down;
                pin_drive_o[i*4 +: 4] <= p.drive;
                pin_owner_o[i*3 +: 3] <= p.owner;
            end
        end
    end

    // ========================================
    // AXI4-Lite read path
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= gpsl_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            logic [31:0] d;
            d = 32'h00000000;
            if (is_setup(s_axi_araddr)) begin
                d = setup_reg[pin_idx(s_axi_araddr)];
                if (s_axi_arprot[1]) begin
                    d = d & ~gpsl_pkg::OWNER_MASK;
                end
            end else if (s_axi_araddr == gpsl_pkg::OFF_HIT_FLAGS) begin
                d = hit_flags_reg;
            end else if (s_axi_araddr == gpsl_pkg::OFF_STYLE_NS) begin
                d = style_ns_reg;
            end else if (s_axi_araddr == gpsl_pkg::OFF_STYLE_S) begin
                d = s_axi_arprot[1] ? 32'h00000000 : style_s_reg;
            end else if (s_axi_araddr == gpsl_pkg::OFF_IRQ_MASK) begin
                d = irq_mask_reg;
            end else if (s_axi_araddr == gpsl_pkg::OFF_PIN_LEVEL) begin
                d = pin_level_i;
            end else if (s_axi_araddr == gpsl_pkg::OFF_PIN_SECURE) begin
                d = pin_secure_i;
            end
            s_axi_rdata <= d;
            s_axi_rresp <= resp_of(s_axi_araddr);
            // Ready stays low until the data is taken: one read in flight
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule // gpsl_top

// ===== testbench/gpsl_pins_model.sv
// Pin-side model: drives chosen pins, leaves the rest to the pulls
module gpsl_pins_model (
    input wire logic mclk_i,
    input wire logic [31:0] drv_val_i,
    input wire logic [31:0] drv_en_i,
    input wire logic [31:0] pull_up_i,
    input wire logic [31:0] pull_down_i,
    output logic [31:0] pin_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_level_o = 32'h0;
    // A floating pin without pull keeps toggling, so a stale value never
    // passes for a real level
    always @(posedge mclk_i) begin
        pin_level_o <= (drv_en_i & drv_val_i) | (~drv_en_i & (pull_up_i |
            (~pull_down_i & ~pin_level_o)));
    end
endmodule // gpsl_pins_model

// ===== testbench/gpsl_top_sva.sv
// Concurrent checks on the register bus and the pad outputs
module gpsl_top_sva (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] pin_dir_out_o,
    input wire logic [31:0] pin_inbuf_on_o,
    input wire logic [31:0] pin_pull_up_o,
    input wire logic [31:0] pin_pull_down_o,
    input wire logic [95:0] pin_owner_o,
    input wire logic detect_ns_o,
    input wire logic detect_s_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    // ========================================
    // Properties
    AST_RST_OUT: assert property (
        $rose(rst_b_i) |-> pin_dir_out_o == 32'h0 && pin_inbuf_on_o == 32'h0
        && pin_owner_o == 96'h0 && !irq_o && !detect_ns_o && !detect_s_o)
        else $error("outputs not clear after reset");
    AST_PULL_EXCL: assert property (
        (pin_pull_up_o & pin_pull_down_o) == 32'h0)
        else $error("pull-up and pull-down on together");
    AST_BV_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_RV_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_RD_LAT: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_WR_LAT: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after request");
    AST_AR_BUSY: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while a read is pending");
    AST_W_BUSY: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while a write is pending");
endmodule // gpsl_top_sva

// ===== testbench/gpsl_top_test.sv
// Self-checking bench for the pin setup and sense latch block
module gpsl_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, pin_secure_i = 32'h10;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, detect_ns_o, detect_s_o, irq_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, pin_level_i, pin_dir_out_o, pin_inbuf_on_o;
    logic [31:0] pin_pull_up_o, pin_pull_down_o, rd;
    logic [31:0] drv_val = 32'h0, drv_en = 32'h0;
    logic [127:0] pin_drive_o;
    logic [95:0] pin_owner_o;
    logic [3:0] dc [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
        4'hb};
    logic [3:0] dx [9] = '{4'h5, 4'h9, 4'h6, 4'ha, 4'h1, 4'h2, 4'h4, 4'h8,
        4'hf};
    logic [2:0] oc [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int bad_count = 0, check_count = 0;
    always #20 mclk_i = ~mclk_i;
    gpsl_top uut (.*);
    gpsl_pins_model pins (.mclk_i(mclk_i), .drv_val_i(drv_val),
        .drv_en_i(drv_en), .pull_up_i(pin_pull_up_o),
        .pull_down_i(pin_pull_down_o), .pin_level_o(pin_level_i));
    // ========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Response ready is offered with the request, so the answer is taken
    // at the first edge at which it shows
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [2:0] p = 3'h0);
        bit b;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_awprot <= p;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid === 1'b1;
            rsp = s_axi_bresp;
        end while (!b);
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic rdw(input logic [11:0] a, input logic [2:0] p = 3'h0);
        bit b;
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arprot <= p;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            b = s_axi_rvalid === 1'b1;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
        end while (!b);
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp,
        input logic [2:0] p = 3'h0);
        rdw(a, p);
        chk(rd, exp);
    endtask
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", bad_count, check_count);
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ========================================
    // Sequence
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rc(12'h020, 32'h0);
        rc(12'h200, 32'h2);
        rc(12'h27c, 32'h2);
        rc(12'h024, 32'h0);
        rc(12'h038, 32'h10);
        chk(pin_inbuf_on_o, 32'h0);
        wr(12'h27c, 32'h70000b0d);
        rc(12'h27c, 32'h70000b0d);
        chk({pin_dir_out_o[31], pin_inbuf_on_o[31], pin_pull_up_o[31],
            pin_drive_o[127:124], pin_owner_o[95:93]}, 32'h3ff);
        for (int i = 0; i < 9; i++) begin
            wr(12'h204, {20'h0, dc[i], 8'h0});
            chk(pin_drive_o[7:4], dx[i]);
        end
        for (int i = 0; i < 3; i++) begin
            wr(12'h208, {28'h0, (i == 2) ? 2'h3 : 2'(i), 2'h0});
            chk({pin_pull_up_o[2], pin_pull_down_o[2]}, {i == 2, i == 1});
        end
        for (int i = 0; i < 4; i++) begin
            wr(12'h200, {1'b0, oc[i], 28'h2});
            chk(pin_owner_o[2:0], oc[i]);
        end
        wr(12'h200, 32'h10000002, 3'h2);
        chk(pin_owner_o[2:0], 3'h7);
        rc(12'h200, 32'h2, 3'h2);
        rc(12'h200, 32'h70000002);
        drv_en <= 32'h18;
        wr(12'h20c, 32'h00020000);
        wr(12'h030, 32'h8);
        rc(12'h030, 32'h8);
        rc(12'h020, 32'h0);
        drv_val <= 32'h8;
        repeat (4) @(posedge mclk_i);
        chk({detect_ns_o, irq_o}, 32'h3);
        rc(12'h020, 32'h8);
        drv_val <= 32'h0;
        repeat (3) @(posedge mclk_i);
        chk(detect_ns_o, 32'h0);
        rc(12'h020, 32'h8);
        wr(12'h020, 32'hfffffff7);
        rc(12'h020, 32'h8);
        wr(12'h024, 32'h1);
        rc(12'h024, 32'h1);
        chk({detect_ns_o, detect_s_o}, 32'h2);
        wr(12'h030, 32'h0);
        chk(irq_o, 32'h0);
        wr(12'h030, 32'h8);
        chk(irq_o, 32'h1);
        wr(12'h020, 32'h8);
        rc(12'h020, 32'h0);
        chk({detect_ns_o, irq_o}, 32'h0);
        wr(12'h210, 32'h00030000);
        rc(12'h020, 32'h10);
        wr(12'h028, 32'h1, 3'h2);
        rc(12'h028, 32'h0);
        wr(12'h028, 32'h1);
        rc(12'h028, 32'h1);
        chk({detect_ns_o, detect_s_o}, 32'h1);
        drv_val <= 32'h10;
        wr(12'h020, 32'h10);
        chk(detect_s_o, 32'h0);
        wr(12'h100, 32'h1);
        chk(rsp, gpsl_pkg::RESP_SLVERR);
        rc(12'h100, 32'h0);
        chk(rsp, gpsl_pkg::RESP_SLVERR);
        finish_test();
    end
    initial begin
        #200us;
        bad_count++;
        finish_test();
    end
endmodule // gpsl_top_test
bind gpsl_top gpsl_top_sva chk (.*);
